// ---- inc/led_cfg_regs.svh ----
/*
  Register offsets, field positions, reset values and timing counts
  of the LED driver configuration bank.
  Assumes a word-indexed register port of 5 address bits.
*/
`ifndef LED_CFG_REGS_SVH
`define LED_CFG_REGS_SVH

// ----------------------------------------------------------------
// Register offsets (word index)
// ----------------------------------------------------------------
`define OFS_RAIL1_OC_LIMIT      5'h00
`define OFS_RAIL2_OC_LIMIT      5'h01
`define OFS_HEAT_WARN_LIMIT     5'h02
`define OFS_HEAT_TRIP_LIMIT     5'h03
`define OFS_HIGH_VOLT_LIMIT     5'h04
`define OFS_LOW_VOLT_LIMIT      5'h05
`define OFS_HYS_BASE            5'h08
`define OFS_DIMMING             5'h10
`define OFS_SWITCH_RATE         5'h11
`define OFS_SLOPE               5'h12
`define OFS_PSIG                5'h13
`define OFS_DEVIATION           5'h14
`define OFS_MODULATION          5'h15
`define OFS_IRQ_STATUS          5'h18
`define OFS_IRQ_MASK            5'h19

// ----------------------------------------------------------------
// Field positions and masks
// ----------------------------------------------------------------
`define LIMIT_LSB               6
`define LIMIT_OFF               10'h3ff
`define HYS_MASK                8'h7f
`define EN_BIT                  7
`define SLOPE_MASK              8'h0f
`define DEV_MASK                8'h67
`define MOD_MASK                8'h03
`define TABLE_LSB               5

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define RST_LIMIT               16'hffff
`define RST_HYS                 8'h0a
`define RST_DIMMING             8'h00
`define RST_SWITCH_RATE         8'h04
`define RST_SLOPE               8'h0a
`define RST_PSIG                8'h84
`define RST_DEVIATION           8'h06
`define RST_MODULATION          8'h01

// ----------------------------------------------------------------
// Timing (25 MHz clock)
// ----------------------------------------------------------------
`define CLK_HZ                  25000000
`define PSIG_SHORT_MS           7
`define PSIG_LONG_MS            75
`define CYC_PER_MS              (`CLK_HZ / 1000)

`endif

// ---- inc/led_cfg_pkg.sv ----
/*
  Types shared by the configuration bank and its detector.
  Assumes the register header is included alongside.
*/
package led_cfg_pkg;
  typedef logic [9:0] limit_t;    // Threshold or measurement value
  typedef logic [6:0] hys_t;      // Hysteresis amount
  typedef enum logic {DIR_ABOVE, DIR_BELOW} trip_dir_e;
  typedef enum {PS_IDLE, PS_PULSE} psig_state_e;
endpackage

// ---- inc/led_det_if.sv ----
/*
  Bundle between the bank and one threshold detector.
  Assumes one clock shared by both ends.
*/
`timescale 1ns/100ps
interface led_det_if;
  led_cfg_pkg::limit_t    meas;     // Measurement sample
  led_cfg_pkg::limit_t    limit;    // Programmed threshold
  led_cfg_pkg::hys_t      hys;      // Programmed hysteresis
  led_cfg_pkg::trip_dir_e dir;      // Crossing direction
  logic                   alert;    // Detector output
  modport bank (output meas, output limit, output hys, output dir, input alert);
  modport det  (input meas, input limit, input hys, input dir, output alert);
endinterface

// ---- hdl/led_threshold_det.sv ----
/*
  One threshold detector with hysteresis.
  Assumes measurement samples synchronous to CLK.
*/
`timescale 1ns/100ps
`include "led_cfg_regs.svh"
module led_threshold_det (
  input  wire logic CLK,
  input  wire logic RST_B,
  led_det_if.det    port_i
);
  logic             alert_r;   // Held alert
  logic             alert_nxt; // Next alert
  logic      [10:0] rel_lvl;   // Release level

  // Alert set on crossing, released past the hysteresis band
  always_comb begin
    alert_nxt = alert_r;
    rel_lvl   = 11'h000;
    if (port_i.limit == `LIMIT_OFF) begin
      alert_nxt = 1'b0;
    end else if (port_i.dir == led_cfg_pkg::DIR_ABOVE) begin
      rel_lvl = {1'b0, port_i.limit} - {4'h0, port_i.hys};
      if (port_i.meas > port_i.limit) begin
        alert_nxt = 1'b1;
      end else if ({1'b0, port_i.meas} < rel_lvl || port_i.hys > port_i.limit) begin
        alert_nxt = (port_i.hys > port_i.limit) ? alert_r : 1'b0;
      end
    end else begin
      rel_lvl = {1'b0, port_i.limit} + {4'h0, port_i.hys};
      if (port_i.meas < port_i.limit) begin
        alert_nxt = 1'b1;
      end else if ({1'b0, port_i.meas} > rel_lvl) begin
        alert_nxt = 1'b0;
      end
    end
  end

  // Register alert
  always_ff @(posedge CLK) begin
    if (!RST_B) begin
      alert_r <= 1'b0;
    end else begin
      alert_r <= alert_nxt;
    end
  end

  assign port_i.alert = alert_r;
endmodule

// ---- hdl/led_cfg_bank.sv ----
/*
  Configuration register bank of an LED driver controller: thresholds,
  hysteresis, dimming, switching rate, slope, power signature and
  spread spectrum, plus alert detectors and an interrupt.
  Assumes a one-cycle register port and synchronous measurement inputs.
*/
// How it works
// - Rate code selects 1 MHz down to 173 kHz
// - Frequency bit 7 enables spread spectrum
// - Dimming bit 7 enables, bits 0-6 DAC
// - High-duty slope 0.3 to 0.9 V/us
// - Low-duty slope 0.1 to 0.4 V/us
// - Signature bit 7 enables signature pulse
// - Minimum pulse 7 ms or 75 ms
// - Extension adds 0 to 127 ms
// - Table field 0 passes codes directly
// - Table field 1 maps codes via table
// - Deviation code 1.8 MHz down to 56 kHz
// - Modulation code 200 to 1600 Hz
// - Hysteresis is 7 bits, bit 7 zero
// - Six thresholds share one layout
// - Threshold value in bits 6 to 15
// - Value 1023 disables the detection
`timescale 1ns/100ps
`include "led_cfg_regs.svh"
module led_cfg_bank (
  input  wire logic        CLK,
  input  wire logic        RST_B,
  input  wire logic [4:0]  ADDR,
  input  wire logic [15:0] WDATA,
  input  wire logic        WR,
  input  wire logic        RD,
  output logic      [15:0] RDATA,
  input  wire logic [59:0] MEAS,
  input  wire logic        LOW_FREQUENCY_CONTROL_BIT,
  output logic             INTERNAL_DIMMING_ON,
  output logic      [6:0]  DIMMING_DAC_SETTING,
  output logic      [6:0]  SWITCH_RATE_CODE,
  output logic      [19:0] SWITCH_RATE_KHZ,
  output logic             SPREAD_SPECTRUM_ON,
  output logic      [1:0]  HIGH_DUTY_SLOPE,
  output logic      [1:0]  LOW_DUTY_SLOPE,
  output logic      [3:0]  HIGH_SLOPE_CV_US,
  output logic      [3:0]  LOW_SLOPE_CV_US,
  output logic             POWER_SIGNATURE_PULSE,
  output logic      [2:0]  DEVIATION_CODE,
  output logic      [1:0]  MODULATION_RATE_CODE,
  output logic      [11:0] DEVIATION_KHZ,
  output logic      [10:0] MODULATION_HZ,
  output logic             SPREAD_TABLE_MODE,
  output logic      [5:0]  ALERTS,
  output logic             IRQ
);
  // ----------------------------------------------------------------
  // Decode helpers
  // ----------------------------------------------------------------
  // Switching rate in kHz for a code; codes past 15 hold the lowest rate
  function automatic logic [19:0] rate_khz(input logic [6:0] c);
    case (c)
      7'h00:   rate_khz = 20'h003e8;
      7'h01:   rate_khz = 20'h00320;
      7'h02:   rate_khz = 20'h0029a;
      7'h03:   rate_khz = 20'h0023b;
      7'h04:   rate_khz = 20'h001f4;
      7'h05:   rate_khz = 20'h001bc;
      7'h06:   rate_khz = 20'h00190;
      7'h07:   rate_khz = 20'h0016b;
      7'h08:   rate_khz = 20'h0014d;
      7'h09:   rate_khz = 20'h00133;
      7'h0a:   rate_khz = 20'h0011d;
      7'h0b:   rate_khz = 20'h000fa;
      7'h0c:   rate_khz = 20'h000eb;
      7'h0d:   rate_khz = 20'h000d2;
      7'h0e:   rate_khz = 20'h000be;
      default: rate_khz = 20'h000ad;
    endcase
  endfunction

  // Deviation in kHz for a code
  function automatic logic [11:0] dev_khz(input logic [2:0] c);
    case (c)
      3'h0:    dev_khz = 12'h708;
      3'h1:    dev_khz = 12'h392;
      3'h2:    dev_khz = 12'h1df;
      3'h3:    dev_khz = 12'h142;
      3'h4:    dev_khz = 12'h0f6;
      3'h5:    dev_khz = 12'h0a5;
      3'h6:    dev_khz = 12'h064;
      default: dev_khz = 12'h038;
    endcase
  endfunction

  // Hysteresis register index for an address, 3'h7 when none
  function automatic logic [2:0] hys_idx(input logic [4:0] a);
    if (a >= `OFS_HYS_BASE && a < `OFS_HYS_BASE + 5'h06) begin
      hys_idx = 3'(a - `OFS_HYS_BASE);
    end else begin
      hys_idx = 3'h7;
    end
  endfunction

  // ----------------------------------------------------------------
  // Register state
  // ----------------------------------------------------------------
  logic [9:0]  limit_r [6];   // Six threshold values
  logic [9:0]  limit_nxt [6];
  logic [6:0]  hys_r [6];     // Six hysteresis values
  logic [6:0]  hys_nxt [6];
  logic [7:0]  dim_r,  dim_nxt;
  logic [7:0]  rate_r, rate_nxt;
  logic [3:0]  slope_r, slope_nxt;
  logic [7:0]  psig_r, psig_nxt;
  logic [1:0]  table_r, table_nxt;
  logic [2:0]  dev_r,  dev_nxt;
  logic [1:0]  mod_r,  mod_nxt;
  logic [5:0]  stat_r, stat_nxt;  // Sticky alert events
  logic [5:0]  mask_r, mask_nxt;  // Interrupt enables
  logic [5:0]  alert_q;           // Previous alerts for edge
  logic [15:0] rdata_nxt;

  // Register writes and sticky status
  always_comb begin
    for (int i = 0; i < 6; i++) begin
      limit_nxt[i] = limit_r[i];
      hys_nxt[i]   = hys_r[i];
    end
    dim_nxt   = dim_r;
    rate_nxt  = rate_r;
    slope_nxt = slope_r;
    psig_nxt  = psig_r;
    table_nxt = table_r;
    dev_nxt   = dev_r;
    mod_nxt   = mod_r;
    mask_nxt  = mask_r;
    stat_nxt  = stat_r;
    if (WR) begin
      if (ADDR <= `OFS_LOW_VOLT_LIMIT) begin
        limit_nxt[ADDR[2:0]] = WDATA[15:`LIMIT_LSB];
      end
      if (hys_idx(ADDR) != 3'h7) begin
        hys_nxt[hys_idx(ADDR)] = WDATA[6:0];
      end
      case (ADDR)
        `OFS_DIMMING:     dim_nxt   = WDATA[7:0];
        `OFS_SWITCH_RATE: rate_nxt  = WDATA[7:0];
        `OFS_SLOPE:       slope_nxt = WDATA[3:0];
        `OFS_PSIG:        psig_nxt  = WDATA[7:0];
        `OFS_DEVIATION: begin
          table_nxt = WDATA[6:`TABLE_LSB];
          dev_nxt   = WDATA[2:0];
        end
        `OFS_MODULATION:  mod_nxt   = WDATA[1:0];
        `OFS_IRQ_MASK:    mask_nxt  = WDATA[5:0];
        `OFS_IRQ_STATUS:  stat_nxt  = stat_r & ~WDATA[5:0];
        default:          ;
      endcase
    end
    // New alert edge wins over a clear in the same cycle
    stat_nxt = stat_nxt | (ALERTS & ~alert_q);
  end

  // Register file flops
  always_ff @(posedge CLK) begin
    if (!RST_B) begin
      for (int i = 0; i < 6; i++) begin
        limit_r[i] <= 10'(`RST_LIMIT >> `LIMIT_LSB);
        hys_r[i]   <= 7'(`RST_HYS);
      end
      dim_r   <= `RST_DIMMING;
      rate_r  <= `RST_SWITCH_RATE;
      slope_r <= 4'(`RST_SLOPE);
      psig_r  <= `RST_PSIG;
      table_r <= 2'h0;
      dev_r   <= 3'(`RST_DEVIATION);
      mod_r   <= 2'(`RST_MODULATION);
      stat_r  <= 6'h00;
      mask_r  <= 6'h00;
      alert_q <= 6'h00;
    end else begin
      for (int i = 0; i < 6; i++) begin
        limit_r[i] <= limit_nxt[i];
        hys_r[i]   <= hys_nxt[i];
      end
      dim_r   <= dim_nxt;
      rate_r  <= rate_nxt;
      slope_r <= slope_nxt;
      psig_r  <= psig_nxt;
      table_r <= table_nxt;
      dev_r   <= dev_nxt;
      mod_r   <= mod_nxt;
      stat_r  <= stat_nxt;
      mask_r  <= mask_nxt;
      alert_q <= ALERTS;
    end
  end

  // ----------------------------------------------------------------
  // Read port
  // ----------------------------------------------------------------
  // Read mux; reserved bits and unmapped addresses give zero
  always_comb begin
    rdata_nxt = 16'h0000;
    if (ADDR <= `OFS_LOW_VOLT_LIMIT) begin
      rdata_nxt = {limit_r[ADDR[2:0]], 6'h00};
    end else if (hys_idx(ADDR) != 3'h7) begin
      rdata_nxt = {9'h000, hys_r[hys_idx(ADDR)]};
    end else begin
      case (ADDR)
        `OFS_DIMMING:     rdata_nxt = {8'h00, dim_r};
        `OFS_SWITCH_RATE: rdata_nxt = {8'h00, rate_r};
        `OFS_SLOPE:       rdata_nxt = {12'h000, slope_r};
        `OFS_PSIG:        rdata_nxt = {8'h00, psig_r};
        `OFS_DEVIATION:   rdata_nxt = {9'h000, table_r, 2'h0, dev_r};
        `OFS_MODULATION:  rdata_nxt = {14'h0000, mod_r};
        `OFS_IRQ_STATUS:  rdata_nxt = {10'h000, stat_r};
        `OFS_IRQ_MASK:    rdata_nxt = {10'h000, mask_r};
        default:          rdata_nxt = 16'h0000;
      endcase
    end
  end

  // Read data held one cycle after the strobe
  always_ff @(posedge CLK) begin
    if (!RST_B) begin
      RDATA <= 16'h0000;
    end else begin
      RDATA <= RD ? rdata_nxt : 16'h0000;
    end
  end

  // ----------------------------------------------------------------
  // Detectors: 0,1 overcurrent, 2,3 heat, 4 high volt above; 5 low below
  // ----------------------------------------------------------------
  led_det_if det_bus [6] ();
  for (genvar g = 0; g < 6; g++) begin : g_det
    assign det_bus[g].meas  = MEAS[g*10 +: 10];
    assign det_bus[g].limit = limit_r[g];
    assign det_bus[g].hys   = hys_r[g];
    assign det_bus[g].dir   = (g == 5) ? led_cfg_pkg::DIR_BELOW : led_cfg_pkg::DIR_ABOVE;
    assign ALERTS[g]        = det_bus[g].alert;
    led_threshold_det u_det (
      .CLK    (CLK),
      .RST_B  (RST_B),
      .port_i (det_bus[g])
    );
  end

  assign IRQ = |(stat_r & mask_r);

  // ----------------------------------------------------------------
  // Converter settings
  // ----------------------------------------------------------------
  assign INTERNAL_DIMMING_ON  = dim_r[`EN_BIT];
  assign DIMMING_DAC_SETTING  = dim_r[6:0];
  assign SWITCH_RATE_CODE     = rate_r[6:0];
  assign SWITCH_RATE_KHZ      = rate_khz(rate_r[6:0]);
  assign SPREAD_SPECTRUM_ON   = rate_r[`EN_BIT];
  assign HIGH_DUTY_SLOPE      = slope_r[3:2];
  assign LOW_DUTY_SLOPE       = slope_r[1:0];

  // Slope in tenths of V/us
  always_comb begin
    case (slope_r[3:2])
      2'h0:    HIGH_SLOPE_CV_US = 4'h3;
      2'h1:    HIGH_SLOPE_CV_US = 4'h4;
      2'h2:    HIGH_SLOPE_CV_US = 4'h6;
      default: HIGH_SLOPE_CV_US = 4'h9;
    endcase
    LOW_SLOPE_CV_US = {2'h0, slope_r[1:0]} + 4'h1;
  end

  // Spread settings: direct codes or table mapped
  assign SPREAD_TABLE_MODE    = (table_r == 2'h1);
  assign DEVIATION_CODE       = dev_r;
  assign MODULATION_RATE_CODE = mod_r;
  assign DEVIATION_KHZ        = dev_khz(dev_r);
  assign MODULATION_HZ        = 11'h0c8 << mod_r;

  // ----------------------------------------------------------------
  // Power signature pulse: minimum plus extension, in ms ticks
  // ----------------------------------------------------------------
  led_cfg_pkg::psig_state_e ps_r, ps_nxt;
  logic [14:0] ms_cnt_r, ms_cnt_nxt;   // Cycles within a millisecond
  logic [7:0]  ms_left_r, ms_left_nxt; // Milliseconds left in pulse
  logic [7:0]  ms_len;                 // Programmed pulse length
  localparam logic [14:0] MS_CYC = 15'(`CYC_PER_MS);

  assign ms_len = (LOW_FREQUENCY_CONTROL_BIT ? 8'(`PSIG_SHORT_MS) : 8'(`PSIG_LONG_MS))
                  + {1'b0, psig_r[6:0]};

  // Pulse sequencer, repeats while enabled
  always_comb begin
    ps_nxt      = ps_r;
    ms_cnt_nxt  = ms_cnt_r;
    ms_left_nxt = ms_left_r;
    case (ps_r)
      led_cfg_pkg::PS_IDLE: begin
        if (psig_r[`EN_BIT]) begin
          ps_nxt      = led_cfg_pkg::PS_PULSE;
          ms_cnt_nxt  = 15'h0000;
          ms_left_nxt = ms_len;
        end
      end
      led_cfg_pkg::PS_PULSE: begin
        if (!psig_r[`EN_BIT]) begin
          ps_nxt = led_cfg_pkg::PS_IDLE;
        end else if (ms_cnt_r == MS_CYC - 15'h0001) begin
          ms_cnt_nxt  = 15'h0000;
          ms_left_nxt = ms_left_r - 8'h01;
          if (ms_left_r == 8'h01) begin
            ps_nxt = led_cfg_pkg::PS_IDLE;
          end
        end else begin
          ms_cnt_nxt = ms_cnt_r + 15'h0001;
        end
      end
      default: ps_nxt = led_cfg_pkg::PS_IDLE;
    endcase
  end

  // Pulse sequencer flops
  always_ff @(posedge CLK) begin
    if (!RST_B) begin
      ps_r      <= led_cfg_pkg::PS_IDLE;
      ms_cnt_r  <= 15'h0000;
      ms_left_r <= 8'h00;
    end else begin
      ps_r      <= ps_nxt;
      ms_cnt_r  <= ms_cnt_nxt;
      ms_left_r <= ms_left_nxt;
    end
  end

  assign POWER_SIGNATURE_PULSE = (ps_r == led_cfg_pkg::PS_PULSE);
endmodule

// ---- tb/led_cfg_bank_asserts.sv ----
/*
  Port checker for the LED configuration bank.
  Assumes the bank header and one clock domain.
*/
`timescale 1ns/100ps
`include "led_cfg_regs.svh"
module led_cfg_bank_chk (
  input wire logic        CLK,
  input wire logic        RST_B,
  input wire logic [4:0]  ADDR,
  input wire logic [15:0] WDATA,
  input wire logic        WR,
  input wire logic        RD,
  input wire logic [15:0] RDATA,
  input wire logic        INTERNAL_DIMMING_ON,
  input wire logic [6:0]  DIMMING_DAC_SETTING,
  input wire logic [6:0]  SWITCH_RATE_CODE,
  input wire logic        SPREAD_SPECTRUM_ON,
  input wire logic [1:0]  HIGH_DUTY_SLOPE,
  input wire logic [1:0]  LOW_DUTY_SLOPE,
  input wire logic [3:0]  HIGH_SLOPE_CV_US,
  input wire logic [3:0]  LOW_SLOPE_CV_US,
  input wire logic        POWER_SIGNATURE_PULSE,
  input wire logic [10:0] MODULATION_HZ,
  input wire logic [1:0]  MODULATION_RATE_CODE,
  input wire logic        SPREAD_TABLE_MODE,
  input wire logic [5:0]  ALERTS,
  input wire logic        IRQ
);
  // ----------------------------------------------------------------
  // Clocking and reset for every property
  // ----------------------------------------------------------------
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RST_B);

  a_rdata_idle: assert property (!RD |=> RDATA == 16'h0000)
    else $error("read data not zero outside a read");
  a_spread_write: assert property (WR && ADDR == `OFS_SWITCH_RATE
    |=> SPREAD_SPECTRUM_ON == $past(WDATA[7])) else $error("spread enable wrong");
  a_rate_hold: assert property (!(WR && ADDR == `OFS_SWITCH_RATE)
    |=> $stable(SWITCH_RATE_CODE)) else $error("rate code moved without write");
  a_dim_write: assert property (WR && ADDR == `OFS_DIMMING |=>
    INTERNAL_DIMMING_ON == $past(WDATA[7]) && DIMMING_DAC_SETTING == $past(WDATA[6:0]))
    else $error("dimming fields wrong");
  a_low_slope: assert property (LOW_SLOPE_CV_US == {2'h0, LOW_DUTY_SLOPE} + 4'h1)
    else $error("low duty slope decode wrong");
  a_high_slope: assert property (HIGH_SLOPE_CV_US == ((HIGH_DUTY_SLOPE == 2'h3) ? 4'h9 :
    (HIGH_DUTY_SLOPE == 2'h2) ? 4'h6 : {2'h0, HIGH_DUTY_SLOPE} + 4'h3))
    else $error("high duty slope decode wrong");
  a_mod_decode: assert property (MODULATION_HZ == (11'h0c8 << MODULATION_RATE_CODE))
    else $error("modulation decode wrong");
  a_table_write: assert property (WR && ADDR == `OFS_DEVIATION |=>
    SPREAD_TABLE_MODE == ($past(WDATA[6:5]) == 2'h1)) else $error("table mode wrong");
  a_pulse_off: assert property (WR && ADDR == `OFS_PSIG && !WDATA[7]
    |=> ##2 !POWER_SIGNATURE_PULSE) else $error("pulse kept after disable");
  a_irq_cause: assert property ($rose(IRQ) |-> $past(|ALERTS) ||
    $past(WR && ADDR == `OFS_IRQ_MASK)) else $error("interrupt without cause");

  c_read: cover property (RD ##1 RDATA != 16'h0000);
  c_irq: cover property ($rose(IRQ));
  c_alert: cover property ($rose(ALERTS[1]));
  c_pulse: cover property ($fell(POWER_SIGNATURE_PULSE));
endmodule

bind led_cfg_bank led_cfg_bank_chk chk (.CLK(CLK), .RST_B(RST_B), .ADDR(ADDR),
  .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA), .INTERNAL_DIMMING_ON(INTERNAL_DIMMING_ON),
  .DIMMING_DAC_SETTING(DIMMING_DAC_SETTING), .SWITCH_RATE_CODE(SWITCH_RATE_CODE),
  .SPREAD_SPECTRUM_ON(SPREAD_SPECTRUM_ON), .HIGH_DUTY_SLOPE(HIGH_DUTY_SLOPE),
  .LOW_DUTY_SLOPE(LOW_DUTY_SLOPE), .HIGH_SLOPE_CV_US(HIGH_SLOPE_CV_US),
  .LOW_SLOPE_CV_US(LOW_SLOPE_CV_US), .POWER_SIGNATURE_PULSE(POWER_SIGNATURE_PULSE),
  .MODULATION_HZ(MODULATION_HZ), .MODULATION_RATE_CODE(MODULATION_RATE_CODE),
  .SPREAD_TABLE_MODE(SPREAD_TABLE_MODE), .ALERTS(ALERTS), .IRQ(IRQ));

// ---- tb/tb.sv ----
/*
  Self-checking bench for the LED configuration bank.
  Assumes the bank header and the port checker bound alongside.
*/
`timescale 1ns/100ps
`include "led_cfg_regs.svh"
module tb;
  logic        clk;       // 25 MHz clock
  logic        rst_b;     // Sync reset, active low
  logic [4:0]  addr;      // Register index
  logic [15:0] wdata;     // Write data
  logic        wr;        // Write strobe
  logic        rd;        // Read strobe
  logic [15:0] rdata;     // Read data
  logic [59:0] meas;      // Six measurements
  logic        lfc;       // Short minimum pulse select
  logic        dim_on;
  logic [6:0]  dac;
  logic [19:0] rate_khz;
  logic        ss_on;
  logic [3:0]  hi_cv;
  logic [3:0]  lo_cv;
  logic        pulse;
  logic [2:0]  dev;
  logic [11:0] dev_khz;
  logic [10:0] mod_hz;
  logic        tbl;
  logic [5:0]  alerts;
  logic        irq;
  logic [15:0] rv;        // Last read value
  int          error_cnt;
  int          checks_done;

  led_cfg_bank uut (.CLK(clk), .RST_B(rst_b), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd),
    .RDATA(rdata), .MEAS(meas), .LOW_FREQUENCY_CONTROL_BIT(lfc), .INTERNAL_DIMMING_ON(dim_on),
    .DIMMING_DAC_SETTING(dac), .SWITCH_RATE_CODE(), .SWITCH_RATE_KHZ(rate_khz),
    .SPREAD_SPECTRUM_ON(ss_on), .HIGH_DUTY_SLOPE(), .LOW_DUTY_SLOPE(), .HIGH_SLOPE_CV_US(hi_cv),
    .LOW_SLOPE_CV_US(lo_cv), .POWER_SIGNATURE_PULSE(pulse), .DEVIATION_CODE(dev),
    .MODULATION_RATE_CODE(), .DEVIATION_KHZ(dev_khz), .MODULATION_HZ(mod_hz),
    .SPREAD_TABLE_MODE(tbl), .ALERTS(alerts), .IRQ(irq));

  // ----------------------------------------------------------------
  // Clock, checks and bus cycles
  // ----------------------------------------------------------------
  always #20 clk = ~clk;

  task automatic chk(input logic [19:0] seen, input logic [19:0] exp);
    checks_done++;
    if (seen !== exp) begin
      error_cnt++;
      $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  // One write cycle; outputs settled on return
  task automatic wr_reg(input logic [4:0] a, input logic [15:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    #1;
  endtask

  // One read cycle; data taken in the following cycle
  task automatic rd_reg(input logic [4:0] a);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    rv = rdata;
  endtask

  // Rail 2 measurement, then let the detector settle
  task automatic set_meas(input logic [9:0] v);
    @(posedge clk);
    meas[19:10] <= v;
    repeat (3) @(posedge clk);
    #1;
  endtask

  // Reset value of each index
  function automatic logic [15:0] rst_val(input logic [4:0] a);
    if (a <= 5'h05) return 16'hffc0;
    if (a >= 5'h08 && a <= 5'h0d) return 16'h000a;
    case (a)
      5'h11: return 16'h0004;
      5'h12: return 16'h000a;
      5'h13: return 16'h0084;
      5'h14: return 16'h0006;
      5'h15: return 16'h0001;
      default: return 16'h0000;
    endcase
  endfunction

  // Writable bits of each index
  function automatic logic [15:0] wr_mask(input logic [4:0] a);
    if (a <= 5'h05) return 16'hffc0;
    if (a >= 5'h08 && a <= 5'h0d) return 16'h007f;
    case (a)
      5'h10, 5'h11, 5'h13: return 16'h00ff;
      5'h12: return 16'h000f;
      5'h14: return 16'h0067;
      5'h15: return 16'h0003;
      5'h19: return 16'h003f;
      default: return 16'h0000;
    endcase
  endfunction

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_regs;
    for (int i = 0; i < 32; i++) begin
      rd_reg(5'(i));
      chk(20'(rv), 20'(rst_val(5'(i))));
    end
    for (int i = 0; i < 32; i++) begin
      if (i == 24) continue;  // Status is write-one-to-clear
      wr_reg(5'(i), 16'hffff);
      rd_reg(5'(i));
      chk(20'(rv), 20'(wr_mask(5'(i))));
      wr_reg(5'(i), 16'h0000);
    end
    $display("Register test done");
  endtask

  task automatic t_rate;
    logic [19:0] khz [16] = '{20'h3e8, 20'h320, 20'h29a, 20'h23b, 20'h1f4, 20'h1bc,
                              20'h190, 20'h16b, 20'h14d, 20'h133, 20'h11d, 20'h0fa,
                              20'h0eb, 20'h0d2, 20'h0be, 20'h0ad}; // kHz per code
    for (int i = 0; i < 16; i++) begin
      wr_reg(`OFS_SWITCH_RATE, 16'h0080 | 16'(i));
      chk(rate_khz, khz[i]);
      chk(20'(ss_on), 20'h1);
    end
    wr_reg(`OFS_SWITCH_RATE, 16'h0004);
    chk({rate_khz[18:0], ss_on}, {19'h001f4, 1'b0});
    $display("Rate test done");
  endtask

  task automatic t_spread;
    logic [11:0] dk [8] = '{12'h708, 12'h392, 12'h1df, 12'h142,
                            12'h0f6, 12'h0a5, 12'h064, 12'h038}; // kHz per code
    for (int i = 0; i < 8; i++) begin
      wr_reg(`OFS_DEVIATION, 16'h0020 | 16'(i));
      chk({dev_khz, 7'h0, tbl}, {dk[i], 7'h0, 1'b1});
    end
    for (int i = 0; i < 4; i++) begin
      wr_reg(`OFS_MODULATION, 16'(i));
      chk(20'(mod_hz), 20'h000c8 << i);
    end
    wr_reg(`OFS_DEVIATION, 16'h0003);
    chk({16'h0, dev, tbl}, {16'h0, 3'h3, 1'b0});
    $display("Spread test done");
  endtask

  task automatic t_slope_dim;
    logic [3:0] hv [4] = '{4'h3, 4'h4, 4'h6, 4'h9};
    for (int i = 0; i < 4; i++) begin
      wr_reg(`OFS_SLOPE, 16'(i * 5));
      chk({12'h0, hi_cv, lo_cv}, {12'h0, hv[i], 4'(i + 1)});
    end
    wr_reg(`OFS_DIMMING, 16'h00d5);
    chk({12'h0, dim_on, dac}, {12'h0, 1'b1, 7'h55});
    wr_reg(`OFS_DIMMING, 16'h002a);
    chk({12'h0, dim_on, dac}, {12'h0, 1'b0, 7'h2a});
    $display("Slope and dimming test done");
  endtask

  task automatic t_alert;
    wr_reg(5'h09, 16'h0005);       // Hysteresis of five
    wr_reg(`OFS_IRQ_MASK, 16'h0002);
    wr_reg(5'h01, 16'h7d00);       // Limit of 500
    set_meas(10'h1f5);
    chk({18'h0, alerts[1], irq}, 20'h3);
    set_meas(10'h1ef);
    chk(20'(alerts[1]), 20'h1);
    set_meas(10'h1ee);
    chk({18'h0, alerts[1], irq}, 20'h1);
    rd_reg(`OFS_IRQ_STATUS);
    chk(20'(rv), 20'h2);
    wr_reg(`OFS_IRQ_STATUS, 16'h0002);
    chk(20'(irq), 20'h0);
    wr_reg(5'h01, 16'hffc0);
    wr_reg(5'h05, 16'hffc0);       // Low volt off, its input sits below
    set_meas(10'h3ff);
    chk({17'h0, alerts[5], alerts[1], irq}, 20'h0);
    wr_reg(`OFS_IRQ_MASK, 16'h0000);
    wr_reg(5'h01, 16'h7d00);
    repeat (3) @(posedge clk);
    rd_reg(`OFS_IRQ_STATUS);
    chk({rv, 2'h0, alerts[1], irq}, {16'h2, 2'h0, 1'b1, 1'b0});
    $display("Alert test done");
  endtask

  task automatic t_pulse;
    int highs;
    highs = 0;
    wr_reg(`OFS_PSIG, 16'h0000);
    @(posedge clk);
    #1;
    chk(20'(pulse), 20'h0);
    wr_reg(`OFS_PSIG, 16'h0880);
    repeat (2) @(posedge clk);
    repeat (2000) begin
      @(posedge clk);
      highs += int'(pulse === 1'b1);
    end
    chk(20'(highs), 20'h007d0);
    wr_reg(`OFS_PSIG, 16'h0000);   // Disable in mid pulse
    @(posedge clk);
    #1;
    chk(20'(pulse), 20'h0);
    $display("Pulse test done");
  endtask

  task automatic end_sim;
    $display("Comparisons %0d, mismatches %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Main sequence and hang guard
  // ----------------------------------------------------------------
  initial begin
    clk = 1'b0;
    rst_b = 1'b0;
    addr = 5'h00;
    wdata = 16'h0000;
    wr = 1'b0;
    rd = 1'b0;
    meas = 60'h0;
    lfc = 1'b1;
    error_cnt = 0;
    checks_done = 0;
    repeat (6) @(posedge clk);
    rst_b <= 1'b1;
    t_regs();
    t_rate();
    t_spread();
    t_slope_dim();
    t_alert();
    t_pulse();
    end_sim();
  end

  initial begin
    repeat (100000) @(posedge clk);
    error_cnt++;
    end_sim();
  end
endmodule
